// file: hw/cgmc_mode_control.sv
`timescale 1ns/1ps
// Function
// - Reset in FLL_ENGAGED_INTERNAL; direct exits FEE, FBE, FLL_BYPASSED_INTERNAL.
// - FEE: external reference, source FLL.
// - Source external routes oscillator; FLL keeps running unless pllSelect or lowPowerBypass is set.
// - Internal enable keeps internal reference running.
// - Oscillator ready only after start-up cycles.
// - Reference status clears; source status reads external.
// - Untuned ranges give 640/1280/1920/2560.
// - Tuned ranges give 732/1464/2197/2929.
// - Source internal routes internal reference, status follows.
// - Speed select: clear slow, set fast.
// - Status bits mirror pllSelect and internalSpeedSelect; source and reference status follow the committed mode.
// - Range writes ignored while low-power bypass.
// - System clock source chosen per mode.
// - Low-power bypass disables both FLL and PLL, even in the FLL-engaged modes.
module cgmc_mode_control
	import cgmc_pkg::*;
#(
	parameter int unsigned OSC_STARTUP = OSC_STARTUP_CYC,
	parameter int unsigned SWITCH_CYC  = SWITCH_SETTLE_CYC
) (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire cgmc_ctrl_t ctrl,
	input  wire logic       fllCfgWrite,
	input  wire logic [1:0] fllRange,
	input  wire logic       tune32768Bit,
	output cgmc_stat_t      status,
	output cgmc_drive_t     drive,
	output cgmc_mode_t      currentMode,
	output logic            switchBusy,
	output logic            requestRefused
);

	// ------------------------------------------------------------------
	// Mode helpers
	// ------------------------------------------------------------------
	function automatic cgmc_mode_t modeOf(input cgmc_ctrl_t c);
		cgmc_mode_t m;
		m = FLL_ENGAGED_INTERNAL;
		unique case (c.systemClockSource)
			SRC_FLL: begin
				if (c.pllSelect && !c.referenceSelect) begin
					m = PLL_ENGAGED_EXTERNAL;
				end else if (c.referenceSelect) begin
					m = FLL_ENGAGED_INTERNAL;
				end else begin
					m = FLL_ENGAGED_EXTERNAL;
				end
			end
			SRC_INT: begin
				m = c.lowPowerBypass ? LOW_POWER_BYPASS_INTERNAL
					: FLL_BYPASSED_INTERNAL;
			end
			SRC_EXT: begin
				if (c.lowPowerBypass) begin
					m = LOW_POWER_BYPASS_EXTERNAL;
				end else if (c.pllSelect) begin
					m = PLL_BYPASSED_EXTERNAL;
				end else begin
					m = FLL_BYPASSED_EXTERNAL;
				end
			end
			SRC_PLL: begin
				m = FLL_ENGAGED_INTERNAL;
			end
		endcase
		return m;
	endfunction

	// Source that actually drives the system clock in a mode.
	function automatic logic [1:0] srcOf(input cgmc_mode_t m);
		logic [1:0] s;
		s = SRC_FLL;
		unique case (m)
			FLL_ENGAGED_INTERNAL, FLL_ENGAGED_EXTERNAL: s = SRC_FLL;
			FLL_BYPASSED_INTERNAL, LOW_POWER_BYPASS_INTERNAL: s = SRC_INT;
			FLL_BYPASSED_EXTERNAL, PLL_BYPASSED_EXTERNAL,
			LOW_POWER_BYPASS_EXTERNAL: s = SRC_EXT;
			PLL_ENGAGED_EXTERNAL: s = SRC_PLL;
		endcase
		return s;
	endfunction

	function automatic logic internalRef(input cgmc_mode_t m);
		return (m == FLL_ENGAGED_INTERNAL) || (m == FLL_BYPASSED_INTERNAL)
			|| (m == LOW_POWER_BYPASS_INTERNAL);
	endfunction

	function automatic logic legalStep(input cgmc_mode_t f,
		input cgmc_mode_t t);
		logic ok;
		ok = 1'b0;
		unique case (f)
			FLL_ENGAGED_INTERNAL, FLL_ENGAGED_EXTERNAL: begin
				ok = (t == FLL_ENGAGED_INTERNAL) || (t == FLL_ENGAGED_EXTERNAL)
					|| (t == FLL_BYPASSED_EXTERNAL)
					|| (t == FLL_BYPASSED_INTERNAL);
			end
			FLL_BYPASSED_INTERNAL: begin
				ok = (t != PLL_ENGAGED_EXTERNAL) && (t != PLL_BYPASSED_EXTERNAL)
					&& (t != LOW_POWER_BYPASS_EXTERNAL);
			end
			FLL_BYPASSED_EXTERNAL: begin
				ok = (t != PLL_ENGAGED_EXTERNAL)
					&& (t != LOW_POWER_BYPASS_INTERNAL);
			end
			PLL_BYPASSED_EXTERNAL: begin
				ok = (t == PLL_ENGAGED_EXTERNAL) || (t == FLL_BYPASSED_EXTERNAL)
					|| (t == LOW_POWER_BYPASS_EXTERNAL);
			end
			PLL_ENGAGED_EXTERNAL: ok = (t == PLL_BYPASSED_EXTERNAL);
			LOW_POWER_BYPASS_INTERNAL: ok = (t == FLL_BYPASSED_INTERNAL);
			LOW_POWER_BYPASS_EXTERNAL: begin
				ok = (t == FLL_BYPASSED_EXTERNAL)
					|| (t == PLL_BYPASSED_EXTERNAL);
			end
		endcase
		return ok;
	endfunction

	function automatic logic [11:0] multiplierOf(input logic [1:0] r,
		input logic tuned);
		logic [11:0] m;
		m = MUL_640;
		unique case (r)
			2'h0: m = tuned ? MUL_732  : MUL_640;
			2'h1: m = tuned ? MUL_1464 : MUL_1280;
			2'h2: m = tuned ? MUL_2197 : MUL_1920;
			2'h3: m = tuned ? MUL_2929 : MUL_2560;
		endcase
		return m;
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	cgmc_mode_t  mode_reg;
	cgmc_mode_t  mode_next;
	cgmc_mode_t  target_reg;
	cgmc_mode_t  target_next;
	logic        pending_reg;
	logic        pending_next;
	logic [1:0]  range_reg;
	logic [1:0]  range_next;
	logic        tune_reg;
	logic        tune_next;
	cgmc_stat_t  status_reg;
	cgmc_stat_t  status_next;
	cgmc_drive_t drive_reg;
	cgmc_drive_t drive_next;
	logic        refused_reg;
	logic        refused_next;

	cgmc_mode_t  wanted;
	logic        wantedValid;
	logic        extWanted;
	logic        oscRun;
	logic        oscDone;
	logic        switchDone;

	assign wanted      = modeOf(ctrl);
	assign wantedValid = (ctrl.systemClockSource != SRC_PLL);
	assign extWanted   = !internalRef(wanted);
	assign oscRun      = ctrl.oscillatorRequest && extWanted;

	// The oscillator must finish its start-up count before the flag rises.
	cgmc_settle_timer #(.W(TIMER_W)) oscTimer (
		.clk   (clk),
		.nrst  (nrst),
		.run   (oscRun),
		.limit (TIMER_W'(OSC_STARTUP)),
		.done  (oscDone)
	);

	// The old source keeps the output until the new one is settled, so
	// the output mux never sees a runt pulse from a half-started clock.
	cgmc_settle_timer #(.W(TIMER_W)) switchTimer (
		.clk   (clk),
		.nrst  (nrst),
		.run   (pending_reg),
		.limit (TIMER_W'(SWITCH_CYC)),
		.done  (switchDone)
	);

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		mode_next    = mode_reg;
		target_next  = target_reg;
		pending_next = pending_reg;
		refused_next = 1'b0;
		range_next   = range_reg;
		tune_next    = tune_reg;
		status_next  = status_reg;
		drive_next   = drive_reg;

		if (fllCfgWrite) begin
			tune_next = tune32768Bit;
			if (!ctrl.lowPowerBypass) begin
				range_next = fllRange;
			end
		end

		if (pending_reg) begin
			if (switchDone) begin
				pending_next = 1'b0;
				mode_next    = target_reg;
				status_next.clockSourceStatus     = srcOf(target_reg);
				status_next.referenceSourceStatus = internalRef(target_reg);
				drive_next.sysClkSel              = srcOf(target_reg);
			end
		end else if (!wantedValid || (wanted != mode_reg)) begin
			// The reserved source code decodes to the reset mode, so it must
			// be refused even while that mode is already running.
			if (!wantedValid || !legalStep(mode_reg, wanted)) begin
				refused_next = 1'b1;
			end else if (!oscRun || oscDone) begin
				pending_next = 1'b1;
				target_next  = wanted;
			end
		end

		status_next.pllSelectStatus     = ctrl.pllSelect;
		status_next.internalSpeedStatus = ctrl.internalSpeedSelect;
		status_next.oscillatorReadyFlag = oscDone;

		drive_next.fllMultiplier    = multiplierOf(range_reg, tune_reg);
		drive_next.fllEnable        = !ctrl.lowPowerBypass
			&& !ctrl.pllSelect;
		drive_next.pllEnable        = !ctrl.lowPowerBypass
			&& ctrl.pllSelect;
		drive_next.internalRefRun   = ctrl.internalRefEnable
			|| internalRef(mode_reg) || internalRef(target_reg);
		drive_next.internalRefFast  = ctrl.internalSpeedSelect;
		drive_next.oscillatorEnable = oscRun;
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mode_reg    <= FLL_ENGAGED_INTERNAL;
			target_reg  <= FLL_ENGAGED_INTERNAL;
			pending_reg <= 1'b0;
			refused_reg <= 1'b0;
			range_reg   <= RANGE_LO;
			tune_reg    <= 1'b0;
			status_reg  <= '{clockSourceStatus: SRC_FLL,
				referenceSourceStatus: 1'b1, default: 1'b0};
			drive_reg   <= '{sysClkSel: SRC_FLL, fllMultiplier: MUL_640,
				fllEnable: 1'b1, internalRefRun: 1'b1, default: 1'b0};
		end else begin
			mode_reg    <= mode_next;
			target_reg  <= target_next;
			pending_reg <= pending_next;
			refused_reg <= refused_next;
			range_reg   <= range_next;
			tune_reg    <= tune_next;
			status_reg  <= status_next;
			drive_reg   <= drive_next;
		end
	end

	assign status         = status_reg;
	assign drive          = drive_reg;
	assign currentMode    = mode_reg;
	assign switchBusy     = pending_reg;
	assign requestRefused = refused_reg;
endmodule // cgmc_mode_control

// file: hw/cgmc_pkg.sv
package cgmc_pkg;

	// ------------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------------
	localparam int unsigned CLK_FREQ_HZ        = 20_000_000;
	localparam int unsigned SWITCH_SETTLE_NS   = 200;
	localparam int unsigned SWITCH_SETTLE_CYC  =
		((SWITCH_SETTLE_NS * (CLK_FREQ_HZ / 1_000_000)) + 999) / 1000;
	localparam int unsigned OSC_STARTUP_CYC    = 4096;
	localparam int unsigned TIMER_W            = 16;

	// ------------------------------------------------------------------
	// Field encodings
	// ------------------------------------------------------------------
	localparam logic [1:0] SRC_FLL  = 2'h0;
	localparam logic [1:0] SRC_INT  = 2'h1;
	localparam logic [1:0] SRC_EXT  = 2'h2;
	localparam logic [1:0] SRC_PLL  = 2'h3;
	localparam logic [1:0] RANGE_LO = 2'h0;

	localparam logic [11:0] MUL_640  = 12'h0280;
	localparam logic [11:0] MUL_1280 = 12'h0500;
	localparam logic [11:0] MUL_1920 = 12'h0780;
	localparam logic [11:0] MUL_2560 = 12'h0A00;
	localparam logic [11:0] MUL_732  = 12'h02DC;
	localparam logic [11:0] MUL_1464 = 12'h05B8;
	localparam logic [11:0] MUL_2197 = 12'h0895;
	localparam logic [11:0] MUL_2929 = 12'h0B71;

	// ------------------------------------------------------------------
	// Modes, one-hot
	// ------------------------------------------------------------------
	typedef enum logic [7:0] {
		FLL_ENGAGED_INTERNAL      = 8'h01,
		FLL_ENGAGED_EXTERNAL      = 8'h02,
		FLL_BYPASSED_EXTERNAL     = 8'h04,
		FLL_BYPASSED_INTERNAL     = 8'h08,
		PLL_ENGAGED_EXTERNAL      = 8'h10,
		PLL_BYPASSED_EXTERNAL     = 8'h20,
		LOW_POWER_BYPASS_INTERNAL = 8'h40,
		LOW_POWER_BYPASS_EXTERNAL = 8'h80
	} cgmc_mode_t;

	// ------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [1:0] systemClockSource;
		logic       referenceSelect;
		logic       pllSelect;
		logic       lowPowerBypass;
		logic       internalRefEnable;
		logic       internalSpeedSelect;
		logic       oscillatorRequest;
	} cgmc_ctrl_t;

	typedef struct packed {
		logic [1:0] clockSourceStatus;
		logic       referenceSourceStatus;
		logic       pllSelectStatus;
		logic       internalSpeedStatus;
		logic       oscillatorReadyFlag;
	} cgmc_stat_t;

	typedef struct packed {
		logic [1:0]  sysClkSel;
		logic [11:0] fllMultiplier;
		logic        fllEnable;
		logic        pllEnable;
		logic        internalRefRun;
		logic        internalRefFast;
		logic        oscillatorEnable;
	} cgmc_drive_t;

endpackage

// file: hw/cgmc_settle_timer.sv
`timescale 1ns/1ps
module cgmc_settle_timer
	import cgmc_pkg::*;
#(
	parameter int unsigned W = TIMER_W
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic         run,
	input  wire logic [W-1:0] limit,
	output logic              done
);
	// Counts while run is high; done stays high until run drops.
	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;

	always_comb begin
		count_next = count_reg;
		if (!run) begin
			count_next = '0;
		end else if (count_reg != limit) begin
			count_next = count_reg + {{(W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end

	assign done = run && (count_reg == limit);
endmodule // cgmc_settle_timer

// file: testbench/cgmc_mode_control_props.sv
`timescale 1ns/1ps
module cgmc_mode_control_props
	import cgmc_pkg::*;
#(
	parameter int unsigned OSC_STARTUP = OSC_STARTUP_CYC,
	parameter int unsigned SWITCH_CYC  = SWITCH_SETTLE_CYC
) (
	input wire logic        clk,
	input wire logic        nrst,
	input wire cgmc_ctrl_t  ctrl,
	input wire logic        fllCfgWrite,
	input wire logic [1:0]  fllRange,
	input wire logic        tune32768Bit,
	input wire cgmc_stat_t  status,
	input wire cgmc_drive_t drive,
	input wire cgmc_mode_t  currentMode,
	input wire logic        switchBusy
);
	localparam logic [11:0] MULS [8] = '{MUL_640, MUL_1280, MUL_1920,
		MUL_2560, MUL_732, MUL_1464, MUL_2197, MUL_2929};
	logic [15:0] oscCnt_reg;
	logic [15:0] oscCnt_next;
	logic [15:0] busyCnt_reg;
	logic [15:0] busyCnt_next;
	logic [11:0] expMul;

	// Run lengths let the long waits be checked without long repetitions.
	always_comb begin
		oscCnt_next = ctrl.oscillatorRequest ? oscCnt_reg + 16'h0001 : 16'h0000;
		busyCnt_next = switchBusy ? busyCnt_reg + 16'h0001 : 16'h0000;
		expMul = MULS[{tune32768Bit, fllRange}];
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			oscCnt_reg <= 16'h0000;
			busyCnt_reg <= 16'h0000;
		end else begin
			oscCnt_reg <= oscCnt_next;
			busyCnt_reg <= busyCnt_next;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	src_mirror_a:
		assert property (status.clockSourceStatus == drive.sysClkSel)
		else $error("source status differs from mux select");
	mode_commit_a:
		assert property (!$stable(currentMode) |-> $fell(switchBusy))
		else $error("mode changed outside a commit");
	pll_mirror_a:
		assert property (1'b1 |=> status.pllSelectStatus == $past(ctrl.pllSelect))
		else $error("pll status lags");
	speed_mirror_a:
		assert property (1'b1 |=> status.internalSpeedStatus ==
			$past(ctrl.internalSpeedSelect) && drive.internalRefFast ==
			status.internalSpeedStatus)
		else $error("speed status or select wrong");
	mul_table_a:
		assert property (fllCfgWrite && !ctrl.lowPowerBypass ##1 !fllCfgWrite
			|=> drive.fllMultiplier == $past(expMul, 2))
		else $error("multiplier wrong");
	osc_ready_a:
		assert property ($rose(status.oscillatorReadyFlag) |->
			oscCnt_reg >= OSC_STARTUP)
		else $error("oscillator ready too early");
	osc_drop_a:
		assert property (!ctrl.oscillatorRequest |=> !status.oscillatorReadyFlag)
		else $error("oscillator ready without request");
	busy_len_a:
		assert property ($fell(switchBusy) |-> busyCnt_reg == SWITCH_CYC + 1)
		else $error("switch length wrong");
endmodule // cgmc_mode_control_props

bind cgmc_mode_control cgmc_mode_control_props #(
	.OSC_STARTUP(OSC_STARTUP), .SWITCH_CYC(SWITCH_CYC)) u_cgmc_mode_control_props (
	.clk(clk), .nrst(nrst), .ctrl(ctrl), .fllCfgWrite(fllCfgWrite),
	.fllRange(fllRange), .tune32768Bit(tune32768Bit), .status(status),
	.drive(drive), .currentMode(currentMode), .switchBusy(switchBusy));

// file: testbench/cgmc_mode_control_tb_top.sv
`timescale 1ns/1ps
module cgmc_mode_control_tb_top import cgmc_pkg::*;;
	localparam logic [11:0] MULS [8] = '{MUL_640, MUL_1280, MUL_1920,
		MUL_2560, MUL_732, MUL_1464, MUL_2197, MUL_2929};
	// FEE FBE PLL_BYPASSED_EXTERNAL PLL_ENGAGED_EXTERNAL PLL_BYPASSED_EXTERNAL LOW_POWER_BYPASS_EXTERNAL FBE FLL_BYPASSED_INTERNAL LOW_POWER_BYPASS_INTERNAL FLL_BYPASSED_INTERNAL FLL_ENGAGED_INTERNAL, each a legal step.
	localparam logic [7:0] STEP_C [11] = '{8'h05, 8'h85, 8'h95, 8'h15, 8'h95,
		8'h9D, 8'h81, 8'h67, 8'h6E, 8'h66, 8'h20};
	localparam logic [7:0] STEP_M [11] = '{8'h02, 8'h04, 8'h20, 8'h10, 8'h20,
		8'h80, 8'h04, 8'h08, 8'h40, 8'h08, 8'h01};
	localparam logic [1:0] STEP_S [11] = '{2'h0, 2'h2, 2'h2, 2'h3, 2'h2,
		2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h0};
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	cgmc_ctrl_t  ctrl = 8'h20;
	logic        fllCfgWrite = 1'b0;
	logic [1:0]  fllRange = 2'h0;
	logic        tune32768Bit = 1'b0;
	cgmc_stat_t  status;
	cgmc_drive_t drive;
	cgmc_mode_t  currentMode;
	logic        switchBusy;
	logic        requestRefused;
	int          errCount = 0;
	int          comparisons = 0;

	always #25 clk = ~clk;

	cgmc_mode_control #(.OSC_STARTUP(8), .SWITCH_CYC(2)) u_cgmc_mode_control (
		.clk(clk), .nrst(nrst), .ctrl(ctrl), .fllCfgWrite(fllCfgWrite),
		.fllRange(fllRange), .tune32768Bit(tune32768Bit), .status(status),
		.drive(drive), .currentMode(currentMode), .switchBusy(switchBusy),
		.requestRefused(requestRefused));

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			errCount++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("comparisons=%0d mismatches=%0d", comparisons, errCount);
		if (errCount == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic wr(input logic [1:0] r, input logic t);
		@(posedge clk);
		fllCfgWrite <= 1'b1;
		fllRange <= r;
		tune32768Bit <= t;
		@(posedge clk);
		fllCfgWrite <= 1'b0;
		@(posedge clk);
		#1;
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset();
		chk(currentMode, 16'h0001);
		chk(status, 16'h0008);
		chk(drive.fllMultiplier, MUL_640);
		$display("reset test done");
	endtask
	task automatic t_range();
		// The tuning bit is only tried in an external mode, never in FLL_ENGAGED_INTERNAL.
		@(posedge clk);
		ctrl <= 8'h80;
		repeat (6) @(posedge clk);
		#1;
		chk(currentMode, 16'h0004);
		for (int i = 0; i < 8; i++) begin
			wr(i[1:0], i[2]);
			chk(drive.fllMultiplier, MULS[i]);
		end
		@(posedge clk);
		ctrl.lowPowerBypass <= 1'b1;
		wr(2'h0, 1'b1);
		chk(drive.fllMultiplier, MUL_2929);
		chk(drive.fllEnable, 1'b0);
		@(posedge clk);
		ctrl.lowPowerBypass <= 1'b0;
		wr(2'h0, 1'b0);
		@(posedge clk);
		ctrl <= 8'h20;
		repeat (6) @(posedge clk);
		#1;
		chk(currentMode, 16'h0001);
		$display("range test done");
	endtask
	task automatic t_refuse();
		// PLL_ENGAGED_EXTERNAL straight from reset, then the reserved source code.
		@(posedge clk);
		ctrl <= 8'h15;
		repeat (2) @(posedge clk);
		#1;
		chk(requestRefused, 1'b1);
		@(posedge clk);
		ctrl <= 8'hE0;
		repeat (2) @(posedge clk);
		#1;
		chk(requestRefused, 1'b1);
		@(posedge clk);
		ctrl <= 8'h20;
		repeat (6) @(posedge clk);
		#1;
		chk(currentMode, 16'h0001);
		chk(requestRefused, 1'b0);
		$display("refusal test done");
	endtask
	task automatic t_modes();
		cgmc_ctrl_t c;
		logic       extOsc;
		for (int i = 0; i < 11; i++) begin
			c = STEP_C[i];
			extOsc = c.oscillatorRequest & ~c.referenceSelect;
			@(posedge clk);
			ctrl <= c;
			for (int k = 0; k < 60 && currentMode !== STEP_M[i]; k++) begin
				@(posedge clk);
				#1;
			end
			@(posedge clk);
			#1;
			chk(currentMode, STEP_M[i]);
			chk(status.clockSourceStatus, STEP_S[i]);
			chk(drive.sysClkSel, STEP_S[i]);
			chk(status.referenceSourceStatus, c.referenceSelect);
			chk(status.oscillatorReadyFlag, extOsc);
			chk(drive.oscillatorEnable, extOsc);
			chk(status.pllSelectStatus, c.pllSelect);
			chk(status.internalSpeedStatus, c.internalSpeedSelect);
			chk(drive.internalRefFast, c.internalSpeedSelect);
			chk(drive.pllEnable, c.pllSelect & ~c.lowPowerBypass);
			chk(switchBusy, 1'b0);
			chk(requestRefused, 1'b0);
			chk(drive.internalRefRun, c.internalRefEnable | c.referenceSelect);
			if (!c.pllSelect) chk(drive.fllEnable, !c.lowPowerBypass);
		end
		$display("mode test done");
	endtask

	initial begin
		#200_000;
		errCount++;
		end_sim();
	end
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		#1;
		t_reset();
		t_range();
		t_refuse();
		t_modes();
		end_sim();
	end
endmodule // cgmc_mode_control_tb_top
